// [hw/attn_spi_device.sv]
`timescale 1ns/1ps
module attn_spi_device (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_clk_en,
  attn_spi_if.device      bus,
  input  wire logic       i_comp_level,
  output logic [9:0]      o_dac_code,
  output logic            o_dac_enable,
  output logic            o_ctrl_path_en,
  output logic            o_dac_to_attn,
  output logic            o_comp_route,
  output logic            o_dac_on_ctrl,
  output logic            o_use_ext_ref,
  output logic            o_comp_out
);

  logic [8:0]  s1_q;
  logic [8:0]  s2_q;
  logic [8:0]  s3_q;
  logic [8:0]  pin_q;
  logic [8:0]  prev_q;
  logic [8:0]  raw;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_rise;
  logic        up_rise;
  logic        down_rise;
  logic [3:0]  bit_cnt_q;
  logic [12:0] shift_in_q;
  logic [9:0]  tx_q;
  logic        oe_q;
  logic [9:0]  code_q;
  logic [9:0]  up_inc_q;
  logic [9:0]  down_inc_q;
  logic        comp_en_q;
  logic [10:0] up_steps_q;
  logic [10:0] down_steps_q;
  logic [9:0]  step_code;
  logic        src;
  logic        mode;

  // clamp of m*r1 - n*r2 into the converter range
  function automatic logic [9:0] step_result(input logic [10:0] m, input logic [9:0] r1,
                                              input logic [10:0] n, input logic [9:0] r2);
    logic [22:0] diff;
    // products sized to 23 bits first, a bare product would keep only 11
    diff = 23'(m) * 23'(r1) - 23'(n) * 23'(r2);
    if (diff[22]) begin
      step_result = attn_spi_pkg::CODE_MIN;
    end else if (diff[21:10] != 12'h000) begin
      step_result = attn_spi_pkg::CODE_MAX;
    end else begin
      step_result = diff[9:0];
    end
  endfunction

  // word returned for a read of the given select
  function automatic logic [9:0] read_word(input logic [1:0] sel);
    unique case (sel)
      attn_spi_pkg::REG_CODE: read_word = code_q;
      attn_spi_pkg::REG_UP:   read_word = up_inc_q;
      attn_spi_pkg::REG_DOWN: read_word = down_inc_q;
      attn_spi_pkg::REG_COMP: read_word = {comp_en_q, o_comp_out, 8'h00};
    endcase
  endfunction

  assign raw = {i_comp_level, bus.ref_sel, bus.src_sel, bus.mode, bus.down_n, bus.up_n,
                bus.mosi, bus.cs_n, bus.sclk};

  // three-stage synchroniser; a lane moves once stages two and three agree
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s1_q   <= attn_spi_pkg::PIN_RESET;
      s2_q   <= attn_spi_pkg::PIN_RESET;
      s3_q   <= attn_spi_pkg::PIN_RESET;
      pin_q  <= attn_spi_pkg::PIN_RESET;
      prev_q <= attn_spi_pkg::PIN_RESET;
    end else if (i_clk_en) begin
      s1_q   <= raw;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      pin_q  <= (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
      prev_q <= pin_q;
    end
  end

  assign sclk_rise = pin_q[attn_spi_pkg::P_SCLK] & ~prev_q[attn_spi_pkg::P_SCLK]
                     & ~pin_q[attn_spi_pkg::P_CS_N];
  assign sclk_fall = ~pin_q[attn_spi_pkg::P_SCLK] & prev_q[attn_spi_pkg::P_SCLK];
  assign cs_rise   = pin_q[attn_spi_pkg::P_CS_N] & ~prev_q[attn_spi_pkg::P_CS_N];
  assign up_rise   = pin_q[attn_spi_pkg::P_UP_N] & ~prev_q[attn_spi_pkg::P_UP_N];
  assign down_rise = pin_q[attn_spi_pkg::P_DOWN_N] & ~prev_q[attn_spi_pkg::P_DOWN_N];
  assign src       = pin_q[attn_spi_pkg::P_SRC];
  assign mode      = pin_q[attn_spi_pkg::P_MODE];

  // frame shifter; bits past the thirteenth are not taken
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bit_cnt_q  <= 4'h0;
      shift_in_q <= 13'h0000;
    end else if (i_clk_en) begin
      if (pin_q[attn_spi_pkg::P_CS_N]) begin
        bit_cnt_q <= 4'h0;
      end else if (sclk_rise && bit_cnt_q != attn_spi_pkg::FRAME_LAST) begin
        shift_in_q <= {shift_in_q[11:0], pin_q[attn_spi_pkg::P_MOSI]};
        bit_cnt_q  <= bit_cnt_q + 4'h1;
      end
    end
  end

  // register writes land only on chip select rise after a full write frame
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      code_q     <= attn_spi_pkg::REG_RESET;
      up_inc_q   <= attn_spi_pkg::REG_RESET;
      down_inc_q <= attn_spi_pkg::REG_RESET;
      comp_en_q  <= 1'b0;
    end else if (i_clk_en) begin
      if (cs_rise && bit_cnt_q == attn_spi_pkg::FRAME_LAST && !shift_in_q[12]) begin
        unique case (shift_in_q[11:10])
          attn_spi_pkg::REG_CODE: code_q     <= shift_in_q[9:0];
          attn_spi_pkg::REG_UP:   up_inc_q   <= shift_in_q[9:0];
          attn_spi_pkg::REG_DOWN: down_inc_q <= shift_in_q[9:0];
          attn_spi_pkg::REG_COMP: comp_en_q  <= shift_in_q[attn_spi_pkg::COMP_EN_BIT];
        endcase
      end
    end
  end

  // read path: load on the rise that takes the low select, advance on falls
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_q <= 10'h000;
      oe_q <= 1'b0;
    end else if (i_clk_en) begin
      if (pin_q[attn_spi_pkg::P_CS_N]) begin
        oe_q <= 1'b0;
      end else if (sclk_rise && bit_cnt_q == attn_spi_pkg::ADDR_TAKEN && shift_in_q[1]) begin
        tx_q <= read_word({shift_in_q[0], pin_q[attn_spi_pkg::P_MOSI]});
        oe_q <= 1'b1;
      end else if (sclk_fall && oe_q) begin
        if (bit_cnt_q == attn_spi_pkg::FRAME_LAST) begin
          oe_q <= 1'b0;
        end else if (bit_cnt_q != attn_spi_pkg::READ_FIRST - 4'h1) begin
          // first bit stands over the fall after its load, host samples it late
          tx_q <= {tx_q[8:0], 1'b0};
        end
      end
    end
  end

  assign bus.miso    = tx_q[9];
  assign bus.miso_oe = oe_q;

  assign step_code = step_result(up_steps_q, up_inc_q, down_steps_q, down_inc_q);

  // step counters; kept across mode changes, a step toward the end the code has saturated at is not counted
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      up_steps_q   <= 11'h000;
      down_steps_q <= 11'h000;
    end else if (i_clk_en && mode) begin
      if (!pin_q[attn_spi_pkg::P_UP_N] && !pin_q[attn_spi_pkg::P_DOWN_N]) begin
        up_steps_q   <= 11'h000;
        down_steps_q <= 11'h000;
      // other pin must have stayed high, so leaving a clear is not a step
      end else if (up_rise && pin_q[attn_spi_pkg::P_DOWN_N]
                   && prev_q[attn_spi_pkg::P_DOWN_N]) begin
        if (step_code != attn_spi_pkg::CODE_MAX && up_steps_q != attn_spi_pkg::STEPS_MAX) begin
          up_steps_q <= up_steps_q + 11'h001;
        end
      end else if (down_rise && pin_q[attn_spi_pkg::P_UP_N]
                   && prev_q[attn_spi_pkg::P_UP_N]) begin
        if (step_code != attn_spi_pkg::CODE_MIN && down_steps_q != attn_spi_pkg::STEPS_MAX) begin
          down_steps_q <= down_steps_q + 11'h001;
        end
      end
    end
  end

  // converter code and switch states, all registered
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_dac_code     <= attn_spi_pkg::REG_RESET;
      o_dac_enable   <= 1'b0;
      o_ctrl_path_en <= 1'b1;
      o_dac_to_attn  <= 1'b0;
      o_comp_route   <= 1'b0;
      o_dac_on_ctrl  <= 1'b0;
      o_use_ext_ref  <= 1'b0;
      o_comp_out     <= 1'b1;
    end else if (i_clk_en) begin
      o_dac_code     <= mode ? step_code : code_q;
      o_dac_enable   <= src | comp_en_q;
      o_ctrl_path_en <= ~src | comp_en_q;
      o_dac_to_attn  <= src;
      o_comp_route   <= ~src & comp_en_q;
      o_dac_on_ctrl  <= src & comp_en_q;
      o_use_ext_ref  <= pin_q[attn_spi_pkg::P_REFSEL];
      // comparator idles high so a trip reads as a high-to-low change
      o_comp_out     <= (~src & comp_en_q) ? pin_q[attn_spi_pkg::P_COMP] : 1'b1;
    end
  end

endmodule

// [hw/attn_spi_pkg.sv]
package attn_spi_pkg;

  // frame layout: flag, two select bits, ten data bits, msb first
  localparam int         DATA_BITS  = 10;
  localparam logic [3:0] FRAME_LAST = 4'hd;   // 13 bits in a frame
  localparam logic [3:0] ADDR_TAKEN = 4'h2;   // bits taken before the edge that takes the low select
  localparam logic [3:0] READ_FIRST = 4'h4;   // first rise on which the host samples read data

  // register selects
  localparam logic [1:0] REG_CODE = 2'h0;
  localparam logic [1:0] REG_UP   = 2'h1;
  localparam logic [1:0] REG_DOWN = 2'h2;
  localparam logic [1:0] REG_COMP = 2'h3;

  localparam int         COMP_EN_BIT  = 9;
  localparam int         COMP_LVL_BIT = 8;
  localparam logic [9:0] REG_RESET    = 10'h000;
  localparam logic [9:0] CODE_MAX     = 10'h3ff;
  localparam logic [9:0] CODE_MIN     = 10'h000;
  localparam logic [10:0] STEPS_MAX   = 11'h7ff;

  // pin synchroniser lanes in the device
  localparam int         PIN_W     = 9;
  localparam int         P_SCLK    = 0;
  localparam int         P_CS_N    = 1;
  localparam int         P_MOSI    = 2;
  localparam int         P_UP_N    = 3;
  localparam int         P_DOWN_N  = 4;
  localparam int         P_MODE    = 5;
  localparam int         P_SRC     = 6;
  localparam int         P_REFSEL  = 7;
  localparam int         P_COMP    = 8;
  localparam logic [8:0] PIN_RESET = 9'h01a;  // chip select and step pins idle high

  // host timing
  localparam int         SYS_CLK_NS   = 20;
  localparam int         SCLK_HALF_NS = 160;
  localparam int         STEP_LOW_NS  = 320;
  localparam logic [4:0] SCLK_HALF_CYC = 5'((SCLK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
  localparam logic [4:0] STEP_LOW_CYC  = 5'((STEP_LOW_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);

  // host register offsets (byte addresses)
  localparam logic [7:0] WB_CMD    = 8'h00;
  localparam logic [7:0] WB_STATUS = 8'h04;
  localparam logic [7:0] WB_RDATA  = 8'h08;
  localparam logic [7:0] WB_PINS   = 8'h0c;
  localparam logic [7:0] WB_STEP   = 8'h10;

  typedef enum logic [2:0] {H_IDLE, H_FRAME, H_TAIL, H_STEP, H_GAP} host_state_t;

endpackage

// [hw/attn_spi_if.sv]
`timescale 1ns/1ps
interface attn_spi_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic miso_line;
  logic up_n;
  logic down_n;
  logic mode;
  logic src_sel;
  logic ref_sel;

  // undriven data output reads high, as with a pull-up
  assign miso_line = miso_oe ? miso : 1'b1;

  modport device (
    input  cs_n, sclk, mosi, up_n, down_n, mode, src_sel, ref_sel,
    output miso, miso_oe
  );

  modport host (
    output cs_n, sclk, mosi, up_n, down_n, mode, src_sel, ref_sel,
    input  miso_line
  );
endinterface

// [hw/attn_spi_host.sv]
`timescale 1ns/1ps
module attn_spi_host (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_clk_en,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [31:0] i_wb_dat,
  input  wire logic [3:0]  i_wb_sel,
  output logic [31:0]      o_wb_dat,
  output logic             o_wb_ack,
  attn_spi_if.host         bus
);

  attn_spi_pkg::host_state_t state_q;
  logic [4:0]  wait_q;
  logic [3:0]  rises_q;
  logic [12:0] frame_q;
  logic        rw_q;
  logic [9:0]  rx_q;
  logic [2:0]  pins_q;
  logic        cs_n_q;
  logic        sclk_q;
  logic        mosi_q;
  logic        up_n_q;
  logic        down_n_q;
  logic [2:0]  miso_sync_q;
  logic        miso_q;
  logic        hit;
  logic        wr;
  logic        busy;

  assign hit  = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr   = hit & i_wb_we;
  assign busy = (state_q != attn_spi_pkg::H_IDLE);

  // data input from the device, three flops, moves when last two agree
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      miso_sync_q <= 3'h7;
      miso_q      <= 1'b1;
    end else if (i_clk_en) begin
      miso_sync_q <= {miso_sync_q[1:0], bus.miso_line};
      if (miso_sync_q[1] == miso_sync_q[2]) begin
        miso_q <= miso_sync_q[2];
      end
    end
  end

  // classic slave: ack one cycle after the strobe, dropped the next cycle
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
      pins_q   <= 3'h0;
    end else if (i_clk_en) begin
      o_wb_ack <= hit;
      if (hit && !i_wb_we) begin
        unique case (i_wb_adr)
          attn_spi_pkg::WB_STATUS: o_wb_dat <= {31'h0000_0000, busy};
          attn_spi_pkg::WB_RDATA:  o_wb_dat <= {22'h00_0000, rx_q};
          attn_spi_pkg::WB_PINS:   o_wb_dat <= {29'h0000_0000, pins_q};
          default:                 o_wb_dat <= 32'h0000_0000;
        endcase
      end
      if (wr && i_wb_adr == attn_spi_pkg::WB_PINS) begin
        pins_q <= i_wb_dat[2:0];
      end
    end
  end

  // frame and step sequencer; orders while busy are dropped
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q  <= attn_spi_pkg::H_IDLE;
      wait_q   <= 5'h00;
      rises_q  <= 4'h0;
      frame_q  <= 13'h0000;
      rw_q     <= 1'b0;
      rx_q     <= 10'h000;
      cs_n_q   <= 1'b1;
      sclk_q   <= 1'b0;
      mosi_q   <= 1'b0;
      up_n_q   <= 1'b1;
      down_n_q <= 1'b1;
    end else if (i_clk_en) begin
      unique case (state_q)
        attn_spi_pkg::H_IDLE: begin
          wait_q <= 5'h00;
          if (wr && i_wb_adr == attn_spi_pkg::WB_CMD) begin
            frame_q <= i_wb_dat[12:0];
            rw_q    <= i_wb_dat[12];
            mosi_q  <= i_wb_dat[12];   // msb leads
            cs_n_q  <= 1'b0;
            rises_q <= 4'h0;
            state_q <= attn_spi_pkg::H_FRAME;
          end else if (wr && i_wb_adr == attn_spi_pkg::WB_STEP && i_wb_dat[2:0] != 3'h0) begin
            // clear holds both low; otherwise one pin pulses
            up_n_q   <= ~(i_wb_dat[0] | i_wb_dat[2]);
            down_n_q <= ~(i_wb_dat[1] | i_wb_dat[2]) | (i_wb_dat[0] & ~i_wb_dat[2]);
            state_q  <= attn_spi_pkg::H_STEP;
          end
        end
        attn_spi_pkg::H_FRAME: begin
          if (wait_q == attn_spi_pkg::SCLK_HALF_CYC - 5'h01) begin
            wait_q <= 5'h00;
            sclk_q <= ~sclk_q;
            if (!sclk_q) begin
              rises_q <= rises_q + 4'h1;
            end else begin
              // sample late in the high half, long after the device moved its bit
              if (rw_q && rises_q >= attn_spi_pkg::READ_FIRST) begin
                rx_q <= {rx_q[8:0], miso_q};
              end
              frame_q <= {frame_q[11:0], 1'b0};
              mosi_q  <= frame_q[11];
              if (rises_q == attn_spi_pkg::FRAME_LAST) begin
                state_q <= attn_spi_pkg::H_TAIL;
              end
            end
          end else begin
            wait_q <= wait_q + 5'h01;
          end
        end
        attn_spi_pkg::H_TAIL: begin
          if (wait_q == attn_spi_pkg::SCLK_HALF_CYC - 5'h01) begin
            wait_q  <= 5'h00;
            cs_n_q  <= 1'b1;
            state_q <= attn_spi_pkg::H_GAP;
          end else begin
            wait_q <= wait_q + 5'h01;
          end
        end
        attn_spi_pkg::H_STEP: begin
          if (wait_q == attn_spi_pkg::STEP_LOW_CYC - 5'h01) begin
            wait_q   <= 5'h00;
            up_n_q   <= 1'b1;
            down_n_q <= 1'b1;
            state_q  <= attn_spi_pkg::H_GAP;
          end else begin
            wait_q <= wait_q + 5'h01;
          end
        end
        attn_spi_pkg::H_GAP: begin
          if (wait_q == attn_spi_pkg::STEP_LOW_CYC - 5'h01) begin
            state_q <= attn_spi_pkg::H_IDLE;
          end else begin
            wait_q <= wait_q + 5'h01;
          end
        end
      endcase
    end
  end

  assign bus.cs_n    = cs_n_q;
  assign bus.sclk    = sclk_q;
  assign bus.mosi    = mosi_q;
  assign bus.up_n    = up_n_q;
  assign bus.down_n  = down_n_q;
  assign bus.mode    = pins_q[0];
  assign bus.src_sel = pins_q[1];
  assign bus.ref_sel = pins_q[2];

endmodule

// [verification/attn_spi_asserts.sv]
`timescale 1ns/1ps
module attn_spi_asserts (
  input  wire logic i_sys_clk,
  input  wire logic i_reset_n,
  input  wire logic cs_n,
  input  wire logic sclk,
  input  wire logic mosi,
  input  wire logic miso_oe,
  input  wire logic up_n,
  input  wire logic down_n
);
  logic [3:0] rises_q;
  logic       sclk_q;

  // serial clock rises seen in the current frame, cleared while deselected
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rises_q <= 4'h0;
      sclk_q  <= 1'b0;
    end else begin
      sclk_q <= sclk;
      if (cs_n) rises_q <= 4'h0;
      else if (sclk && !sclk_q) rises_q <= rises_q + 4'h1;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  AST_FRAME_LEN: assert property ($rose(cs_n) |-> rises_q == 4'hd)
    else $error("frame closed without thirteen clock rises");
  AST_OE_AFTER_SELECT: assert property ($rose(miso_oe) |-> !cs_n && rises_q == 4'h3)
    else $error("data output enabled at the wrong bit");
  AST_OE_RELEASE: assert property ($fell(miso_oe) |-> rises_q == 4'hd || cs_n)
    else $error("data output released early");
  AST_OE_CS_DROP: assert property ($rose(cs_n) |-> ##[0:8] !miso_oe)
    else $error("data output still driven after deselect");
  AST_CS_GAP: assert property ($rose(cs_n) |=> cs_n [*8])
    else $error("chip select gap too short");
  AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
    else $error("serial clock moved outside a frame");
  AST_HALF_PERIOD: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("serial clock high phase not eight cycles");
  AST_MOSI_HOLD: assert property ($rose(sclk) |-> $stable(mosi) && !cs_n)
    else $error("data input moved at the sampling edge");
  AST_STEP_OTHER_HIGH: assert property (($fell(up_n) != $fell(down_n)) |-> up_n || down_n)
    else $error("step pulse while the other step pin is low");
  AST_STEP_WIDTH: assert property ($fell(up_n) |-> !up_n [*8])
    else $error("step pulse too short");

  // main traffic kinds
  cover property ($rose(miso_oe));
  cover property ($fell(up_n) && down_n);
  cover property ($fell(up_n) && !down_n);
endmodule

// [verification/attenuator_dac_spi_control_bench.sv]
`timescale 1ns/1ps
module attenuator_dac_spi_control_bench;
  logic        i_sys_clk;
  logic        i_reset_n;
  logic        wb_cyc, wb_stb, wb_we, wb_ack, comp_level, cmp;
  logic [7:0]  wb_adr;
  logic [31:0] wb_dat, wb_rdat, rd;
  logic [9:0]  code1, code2, rx;
  logic        dac_en, ctrl_en, to_attn, comp_route, on_ctrl, ext_ref, comp_out;
  int          n_fail, num_checks, j;
  logic [9:0]  regs [3] = '{10'h2a5, 10'h155, 10'h00a};
  logic [2:0]  st_tab [6] = '{3'h2, 3'h1, 3'h1, 3'h1, 3'h1, 3'h2};
  logic [9:0]  st_exp [6] = '{10'h000, 10'h155, 10'h2aa, 10'h3ff, 10'h3ff, 10'h3f5};

  attn_spi_if if1 ();
  attn_spi_if if2 ();

  attn_spi_host attn_spi_host_i (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_clk_en(1'b1),
    .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb), .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_dat(wb_dat),
    .i_wb_sel(4'hf), .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack), .bus(if1.host));
  attn_spi_device attn_spi_device_i (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
    .i_clk_en(1'b1), .bus(if1.device), .i_comp_level(comp_level), .o_dac_code(code1),
    .o_dac_enable(dac_en), .o_ctrl_path_en(ctrl_en), .o_dac_to_attn(to_attn),
    .o_comp_route(comp_route), .o_dac_on_ctrl(on_ctrl), .o_use_ext_ref(ext_ref),
    .o_comp_out(comp_out));
  // second device faces the bench, which breaks the framing on purpose
  attn_spi_device spare_attn_spi_device_i (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
    .i_clk_en(1'b1), .bus(if2.device), .i_comp_level(comp_level), .o_dac_code(code2),
    .o_dac_enable(), .o_ctrl_path_en(), .o_dac_to_attn(), .o_comp_route(), .o_dac_on_ctrl(),
    .o_use_ext_ref(), .o_comp_out());
  attn_spi_asserts attn_spi_asserts_i (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
    .cs_n(if1.cs_n), .sclk(if1.sclk), .mosi(if1.mosi), .miso_oe(if1.miso_oe),
    .up_n(if1.up_n), .down_n(if1.down_n));

  // 50 MHz system clock
  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // a wait that runs out is a mismatch and ends the run
  task automatic expire();
    check(32'h0, 32'h1);
    results();
  endtask

  // classic cycle: hold until ack is sampled at a rising edge, take data and release there
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int k;
    k = 0;
    @(posedge i_sys_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= a;
    wb_dat <= d;
    @(posedge i_sys_clk);
    while (wb_ack !== 1'b1 && k < 20) begin
      @(posedge i_sys_clk);
      k++;
    end
    if (wb_ack !== 1'b1) expire();
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask

  task automatic wait_idle();
    logic [31:0] st;
    int          k;
    st = 32'h1;
    for (k = 0; k < 300 && st[0] !== 1'b0; k++) wb(1'b0, attn_spi_pkg::WB_STATUS, 32'h0, st);
    if (st[0] !== 1'b0) expire();
  endtask

  task automatic frame(input logic rw, input logic [1:0] sel, input logic [9:0] d);
    wb(1'b1, attn_spi_pkg::WB_CMD, {19'h0, rw, sel, d}, rd);
    wait_idle();
  endtask

  task automatic step(input logic [7:0] a, input logic [2:0] s);
    wb(1'b1, a, {29'h0, s}, rd);
    wait_idle();
  endtask

  // code moves only after the pin synchronisers, so poll under a bound
  task automatic wait_code(input logic which, input logic [9:0] exp);
    int k;
    for (k = 0; k < 100 && (which ? code2 : code1) !== exp; k++) @(negedge i_sys_clk);
    check(which ? code2 : code1, exp);
  endtask

  // bit-banged frame on the spare link; nb below 13 cuts it short
  task automatic bang(input logic [12:0] w, input int nb);
    int i;
    @(posedge i_sys_clk);
    if2.cs_n <= 1'b0;
    if2.mosi <= w[12];
    for (i = 0; i < nb; i++) begin
      repeat (8) @(posedge i_sys_clk);
      if2.sclk <= 1'b1;
      repeat (8) @(posedge i_sys_clk);
      if (i >= 3) rx = {rx[8:0], if2.miso_line};
      if2.sclk <= 1'b0;
      if (i < 12) if2.mosi <= w[11-i];
    end
    repeat (8) @(posedge i_sys_clk);
    if2.cs_n <= 1'b1;
    if2.mosi <= ~if2.mosi;  // released line must not look stable
    repeat (16) @(posedge i_sys_clk);
  endtask

  initial begin
    i_reset_n  = 1'b0;
    wb_cyc     = 1'b0;
    wb_stb     = 1'b0;
    wb_we      = 1'b0;
    wb_adr     = 8'h00;
    wb_dat     = 32'h0;
    comp_level = 1'b0;
    n_fail     = 0;
    num_checks = 0;
    rx         = 10'h000;
    if2.cs_n   = 1'b1;
    if2.sclk   = 1'b0;
    if2.mosi   = 1'b0;
    if2.up_n   = 1'b1;
    if2.down_n = 1'b1;
    if2.mode   = 1'b0;
    if2.src_sel = 1'b0;
    if2.ref_sel = 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    // registers written and read back in address order
    for (j = 0; j < 3; j++) frame(1'b0, 2'(j), regs[j]);
    for (j = 0; j < 3; j++) begin
      frame(1'b1, 2'(j), 10'h000);
      wb(1'b0, attn_spi_pkg::WB_RDATA, 32'h0, rd);
      check(rd, {22'h0, regs[j]});
    end
    wait_code(1'b0, 10'h2a5);
    $display("register test done");
    // every source and enable state, with both reference and comparator levels
    for (j = 0; j < 8; j++) begin
      step(attn_spi_pkg::WB_PINS, {j[2], j[0], 1'b0});
      comp_level <= j[2];
      frame(1'b0, attn_spi_pkg::REG_COMP, {j[1], 9'h1ff});
      frame(1'b1, attn_spi_pkg::REG_COMP, 10'h000);
      wb(1'b0, attn_spi_pkg::WB_RDATA, 32'h0, rd);
      cmp = (!j[0] && j[1]) ? j[2] : 1'b1;
      check(rd, {22'h0, j[1], cmp, 8'h00});
      check({dac_en, ctrl_en, to_attn, comp_route, on_ctrl},
            {j[0] | j[1], !j[0] | j[1], j[0], !j[0] & j[1], j[0] & j[1]});
      check({ext_ref, comp_out}, {j[2], cmp});
    end
    $display("control state test done");
    // step mode: clear, saturate both ways, then swap modes
    step(attn_spi_pkg::WB_PINS, 3'h1);
    step(attn_spi_pkg::WB_STEP, 3'h4);
    wait_code(1'b0, 10'h000);
    for (j = 0; j < 6; j++) begin
      step(attn_spi_pkg::WB_STEP, st_tab[j]);
      wait_code(1'b0, st_exp[j]);
    end
    step(attn_spi_pkg::WB_PINS, 3'h0);
    wait_code(1'b0, 10'h2a5);
    step(attn_spi_pkg::WB_STEP, 3'h1);
    step(attn_spi_pkg::WB_STEP, 3'h4);
    wait_code(1'b0, 10'h2a5);
    step(attn_spi_pkg::WB_PINS, 3'h1);
    wait_code(1'b0, 10'h3f5);
    $display("step test done");
    // spare link: full write, short write, read, aborted read
    bang({3'b000, 10'h123}, 13);
    wait_code(1'b1, 10'h123);
    bang({3'b000, 10'h0f0}, 12);
    wait_code(1'b1, 10'h123);
    bang({3'b100, 10'h000}, 13);
    check(rx, 10'h123);
    check({if2.miso_oe, if2.miso_line}, 2'b01);
    bang({3'b100, 10'h000}, 6);
    check({if2.miso_oe, if2.miso_line}, 2'b01);
    $display("link fault test done");
    results();
  end
endmodule
